// [core/smc_dev.sv]
// Function
// - serial command returns three words, crc each
// - host joins words into serial number
// - 48-bit unique serial sent msw first
// - self-test command runs up to 10000 ms
// - self-test word zero means no fault
// - factory restore within 1200 ms, no data
// - factory restore clears recalibration histories
// - reinit reloads settings within 30 ms
// - host sends reinit only when idle
// - variant word in 1 ms, top nibble
// - host decodes only top four bits
// - host waits execution time before reading
//
// Purpose: sensor end of the maintenance command link
// Assumes: host obeys idle and wait rules
// Notes: long waits are parameters so simulation can shorten them
`timescale 1ns/100ps
`default_nettype none
`include "smc_regs.svh"
module smc_dev #(
   parameter logic [47:0] SERIAL = 48'h0123_4567_89ab, // arbitrary value
   parameter logic [3:0] VARIANT = 4'h3, // arbitrary value
   parameter logic [11:0] VAR_LOW = 12'h000,
   parameter int unsigned SELFTEST_CYC =
      `SMC_T_SELFTEST_MS * `SMC_CYC_PER_MS,
   parameter int unsigned FACTORY_CYC = `SMC_T_FACTORY_MS * `SMC_CYC_PER_MS,
   parameter int unsigned REINIT_CYC = `SMC_T_REINIT_MS * `SMC_CYC_PER_MS,
   parameter int unsigned VARIANT_CYC = `SMC_T_VARIANT_MS * `SMC_CYC_PER_MS,
   parameter int unsigned SERIAL_CYC = `SMC_T_SERIAL_MS * `SMC_CYC_PER_MS
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // link
   smc_if.dev link,
   // sensor core side
   input wire logic selftest_fault_i,
   input wire logic [15:0] selftest_code_i,
   output logic factory_restore_o,
   output logic clear_forced_recalibration_o,
   output logic clear_automatic_baseline_correction_o,
   output logic reload_settings_o,
   output logic busy_o
);
   import smc_pkg::*;

   // ==========================================================
   // state
   typedef enum logic [2:0] {
      SMC_IDLE = 3'b001,
      SMC_EXEC = 3'b010,
      SMC_RESP = 3'b100
   } smc_state_t;

   smc_state_t state;
   logic [31:0] timer;
   logic [15:0] cur_cmd;
   smc_word_t words [0:2];
   logic [1:0] nwords;
   logic [1:0] widx;
   logic [1:0] bidx;
   smc_word_t result;

   // execution time chosen per command
   function automatic logic [31:0] exec_cycles(input logic [15:0] c);
      case (c)
         `SMC_CMD_SERIAL: exec_cycles = 32'(SERIAL_CYC);
         `SMC_CMD_SELFTEST: exec_cycles = 32'(SELFTEST_CYC);
         `SMC_CMD_FACTORY: exec_cycles = 32'(FACTORY_CYC);
         `SMC_CMD_REINIT: exec_cycles = 32'(REINIT_CYC);
         `SMC_CMD_VARIANT: exec_cycles = 32'(VARIANT_CYC);
         default: exec_cycles = 32'h0;
      endcase
   endfunction : exec_cycles

   function automatic logic known_cmd(input logic [15:0] c);
      known_cmd = (exec_cycles(c) != 32'h0);
   endfunction : known_cmd

   // commands only accepted in idle; unknown codes are dropped
   assign link.cmd_ready = (state == SMC_IDLE);
   assign busy_o = (state == SMC_EXEC);

   // ==========================================================
   // sequencer
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= SMC_IDLE;
         timer <= 32'h0;
         cur_cmd <= 16'h0;
      end else begin
         case (state)
            SMC_IDLE: begin
               if (link.cmd_valid && known_cmd(link.cmd_code)) begin
                  state <= SMC_EXEC;
                  cur_cmd <= link.cmd_code;
                  timer <= exec_cycles(link.cmd_code) - 32'h1;
               end
            end
            SMC_EXEC: begin
               if (timer != 32'h0) begin
                  timer <= timer - 32'h1;
               end else if (nwords != 2'h0) begin
                  state <= SMC_RESP;
               end else begin
                  state <= SMC_IDLE;
               end
            end
            SMC_RESP: begin
               // last byte read; an unread answer keeps the link busy
               if (link.rd_req && widx == nwords - 2'h1 &&
                  bidx == 2'h2) begin
                  state <= SMC_IDLE;
               end
            end
            default: state <= SMC_IDLE;
         endcase
      end
   end

   // response word count per command
   always_comb begin
      case (cur_cmd)
         `SMC_CMD_SERIAL: nwords = 2'(`SMC_SERIAL_WORDS);
         `SMC_CMD_SELFTEST, `SMC_CMD_VARIANT: nwords = 2'h1;
         default: nwords = 2'h0;
      endcase
   end

   // self-test outcome: zero word when healthy
   assign result = selftest_fault_i ?
      ((selftest_code_i == 16'h0) ? 16'h1 : selftest_code_i) : 16'h0;

   // response words, serial most significant word first
   always_comb begin
      words[0] = SERIAL[47:32];
      words[1] = SERIAL[31:16];
      words[2] = SERIAL[15:0];
      if (cur_cmd == `SMC_CMD_SELFTEST) begin
         words[0] = result;
      end else if (cur_cmd == `SMC_CMD_VARIANT) begin
         words[0] = {VARIANT, VAR_LOW};
      end
   end

   // ==========================================================
   // read byte stream: msb, lsb, crc per word
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         widx <= 2'h0;
         bidx <= 2'h0;
         link.rd_data <= 8'h0;
         link.rd_last <= 1'b0;
      end else if (state != SMC_RESP) begin
         widx <= 2'h0;
         bidx <= 2'h0;
      end else if (link.rd_req) begin
         case (bidx)
            2'h0: link.rd_data <= words[widx][15:8];
            2'h1: link.rd_data <= words[widx][7:0];
            default: link.rd_data <= smc_crc8(words[widx]);
         endcase
         link.rd_last <= (widx == nwords - 2'h1) && (bidx == 2'h2);
         if (bidx == 2'h2) begin
            bidx <= 2'h0;
            widx <= widx + 2'h1;
         end else begin
            bidx <= bidx + 2'h1;
         end
      end
   end

   // ack a read only when response is ready
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         link.rd_ack <= 1'b0;
         link.rd_nack <= 1'b0;
      end else begin
         link.rd_ack <= link.rd_req && (state == SMC_RESP);
         link.rd_nack <= link.rd_req && (state != SMC_RESP);
      end
   end

   // one-cycle pulses to the core at command end
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         factory_restore_o <= 1'b0;
         clear_forced_recalibration_o <= 1'b0;
         clear_automatic_baseline_correction_o <= 1'b0;
         reload_settings_o <= 1'b0;
      end else begin
         factory_restore_o <= 1'b0;
         clear_forced_recalibration_o <= 1'b0;
         clear_automatic_baseline_correction_o <= 1'b0;
         reload_settings_o <= 1'b0;
         if (state == SMC_EXEC && timer == 32'h0) begin
            if (cur_cmd == `SMC_CMD_FACTORY) begin
               factory_restore_o <= 1'b1;
               clear_forced_recalibration_o <= 1'b1;
               clear_automatic_baseline_correction_o <= 1'b1;
            end
            if (cur_cmd == `SMC_CMD_REINIT) begin
               reload_settings_o <= 1'b1;
            end
         end
      end
   end
endmodule : smc_dev
`default_nettype wire

// [shared/smc_regs.svh]
// Purpose: named constants for the sensor maintenance command link
// Assumes: 40 MHz clock, 25 ns period
// Notes: times kept in their own unit, cycle counts derived below
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH
// ==========================================================
// command codes
`define SMC_CMD_SERIAL 16'h3682
`define SMC_CMD_SELFTEST 16'h3639
`define SMC_CMD_FACTORY 16'h3632
`define SMC_CMD_REINIT 16'h3646
`define SMC_CMD_VARIANT 16'h202f
// ==========================================================
// timing
`define SMC_CLK_HZ 40000000
`define SMC_CYC_PER_MS (`SMC_CLK_HZ / 1000)
`define SMC_T_SELFTEST_MS 10000
`define SMC_T_FACTORY_MS 1200
`define SMC_T_REINIT_MS 30
`define SMC_T_VARIANT_MS 1
`define SMC_T_SERIAL_MS 1
// ==========================================================
// response layout
`define SMC_CRC_POLY 8'h31
`define SMC_CRC_INIT 8'hff
`define SMC_VAR_MSB 15
`define SMC_VAR_LSB 12
`define SMC_SERIAL_WORDS 3
`endif

// [shared/smc_pkg.sv]
// Purpose: shared types for the maintenance command link
// Assumes: nothing beyond the constants header
// Notes: crc function used by both ends
`include "smc_regs.svh"
package smc_pkg;
   typedef logic [15:0] smc_word_t;
   typedef logic [7:0] smc_byte_t;
   // crc-8 over two bytes, msb first
   function automatic smc_byte_t smc_crc8(input smc_word_t w);
      smc_byte_t c;
      c = `SMC_CRC_INIT;
      for (int i = 15; i >= 0; i--) begin
         if (c[7] ^ w[i]) begin
            c = {c[6:0], 1'b0} ^ `SMC_CRC_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      return c;
   endfunction : smc_crc8
endpackage : smc_pkg

// [shared/smc_if.sv]
// Purpose: command and response link between host and sensor
// Assumes: one shared clock, byte level transfers
// Notes: i2c framing abstracted to command word and read bytes
`timescale 1ns/100ps
`default_nettype none
interface smc_if;
   logic cmd_valid;
   logic [15:0] cmd_code;
   logic cmd_ready;
   logic rd_req;
   logic rd_ack;
   logic rd_nack;
   logic [7:0] rd_data;
   logic rd_last;
   modport dev (input cmd_valid, cmd_code, rd_req,
      output cmd_ready, rd_ack, rd_nack, rd_data, rd_last);
   modport host (output cmd_valid, cmd_code, rd_req,
      input cmd_ready, rd_ack, rd_nack, rd_data, rd_last);
endinterface : smc_if
`default_nettype wire

// [core/smc_host.sv]
// Purpose: host end that issues maintenance commands and reads answers
// Assumes: device timings as defined in the constants header
// Notes: waits the execution time before reading, retries on nack
`timescale 1ns/100ps
`default_nettype none
`include "smc_regs.svh"
module smc_host #(
   parameter int unsigned SELFTEST_CYC =
      `SMC_T_SELFTEST_MS * `SMC_CYC_PER_MS,
   parameter int unsigned SHORT_CYC = `SMC_T_SERIAL_MS * `SMC_CYC_PER_MS
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // link
   smc_if.host link,
   // user side
   input wire logic req_i,
   input wire logic [15:0] req_cmd_i,
   input wire logic meas_running_i,
   output logic busy_o,
   output logic done_o,
   output logic crc_err_o,
   output logic [47:0] serial_o,
   output logic [3:0] variant_o,
   output logic [15:0] selftest_o
);
   import smc_pkg::*;

   typedef enum logic [3:0] {
      SMH_IDLE = 4'b0001,
      SMH_CMD = 4'b0010,
      SMH_WAIT = 4'b0100,
      SMH_READ = 4'b1000
   } smh_state_t;

   smh_state_t state;
   logic [15:0] cmd;
   logic [31:0] timer;
   logic [47:0] shreg;
   logic [15:0] wbuf;
   logic [1:0] bidx;
   logic [1:0] nread;
   logic has_data;

   assign has_data = (cmd == `SMC_CMD_SERIAL) ||
      (cmd == `SMC_CMD_SELFTEST) || (cmd == `SMC_CMD_VARIANT);
   assign busy_o = (state != SMH_IDLE);
   assign link.cmd_valid = (state == SMH_CMD);
   assign link.cmd_code = cmd;
   assign link.rd_req = (state == SMH_READ) && !link.rd_ack;

   // ==========================================================
   // sequencer
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= SMH_IDLE;
         cmd <= 16'h0;
         timer <= 32'h0;
      end else begin
         case (state)
            SMH_IDLE: begin
               // reinit refused while measuring
               if (req_i && !(req_cmd_i == `SMC_CMD_REINIT &&
                  meas_running_i)) begin
                  cmd <= req_cmd_i;
                  state <= SMH_CMD;
               end
            end
            SMH_CMD: begin
               if (link.cmd_ready) begin
                  state <= SMH_WAIT;
                  timer <= (cmd == `SMC_CMD_SELFTEST) ?
                     32'(SELFTEST_CYC) : 32'(SHORT_CYC);
               end
            end
            SMH_WAIT: begin
               if (timer != 32'h0) begin
                  timer <= timer - 32'h1;
               end else begin
                  state <= has_data ? SMH_READ : SMH_IDLE;
               end
            end
            SMH_READ: begin
               if (link.rd_ack && link.rd_last) begin
                  state <= SMH_IDLE;
               end
            end
            default: state <= SMH_IDLE;
         endcase
      end
   end

   // ==========================================================
   // collect bytes, check crc, assemble words
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bidx <= 2'h0;
         nread <= 2'h0;
         wbuf <= 16'h0;
         shreg <= 48'h0;
         crc_err_o <= 1'b0;
         done_o <= 1'b0;
         serial_o <= 48'h0;
         variant_o <= 4'h0;
         selftest_o <= 16'h0;
      end else begin
         done_o <= 1'b0;
         if (state == SMH_CMD) begin
            bidx <= 2'h0;
            nread <= 2'h0;
            crc_err_o <= 1'b0;
         end
         if (state == SMH_WAIT && timer == 32'h0 && !has_data) begin
            done_o <= 1'b1;
         end
         if (state == SMH_READ && link.rd_ack) begin
            case (bidx)
               2'h0: wbuf[15:8] <= link.rd_data;
               2'h1: wbuf[7:0] <= link.rd_data;
               default: begin
                  if (smc_crc8(wbuf) != link.rd_data) begin
                     crc_err_o <= 1'b1;
                  end
                  shreg <= {shreg[31:0], wbuf};
                  nread <= nread + 2'h1;
               end
            endcase
            bidx <= (bidx == 2'h2) ? 2'h0 : bidx + 2'h1;
            if (link.rd_last) begin
               done_o <= 1'b1;
               if (cmd == `SMC_CMD_SERIAL) begin
                  serial_o <= {shreg[31:0], wbuf};
               end
               if (cmd == `SMC_CMD_VARIANT) begin
                  variant_o <= wbuf[`SMC_VAR_MSB:`SMC_VAR_LSB];
               end
               if (cmd == `SMC_CMD_SELFTEST) begin
                  selftest_o <= wbuf;
               end
            end
         end
      end
   end
endmodule : smc_host
`default_nettype wire

// [verification/smc_link_checker.sv]
// Purpose: timing and framing assertions on the maintenance link
// Assumes: one clock, counts equal to the sensor end's parameters
// Notes: bytes after the first are judged by the bench model
`timescale 1ns/100ps
`default_nettype none
`include "smc_regs.svh"
module smc_link_checker #(
   parameter int unsigned SELFTEST_CYC = 40,
   parameter int unsigned VARIANT_CYC = 10,
   parameter int unsigned SERIAL_CYC = 10,
   parameter logic [47:0] SERIAL = 48'h0,
   parameter logic [3:0] VARIANT = 4'h0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // command side
   input wire logic cmd_valid,
   input wire logic [15:0] cmd_code,
   input wire logic cmd_ready,
   // read side
   input wire logic rd_req,
   input wire logic rd_ack,
   input wire logic rd_nack,
   input wire logic [7:0] rd_data,
   input wire logic rd_last
);
   logic [15:0] last_code;
   logic [15:0] since;
   logic [3:0] nb;
   wire logic taken;
   assign taken = cmd_valid && cmd_ready;
   // ==========================================================
   // helper state
   // cycles since the last accepted command, saturating
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         last_code <= 16'h0000;
         since <= 16'h0000;
      end else if (taken) begin
         last_code <= cmd_code;
         since <= 16'h0000;
      end else if (since != 16'hffff) begin
         since <= since + 16'h0001;
      end
   end
   // answer bytes since the last command, picks out first and last
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         nb <= 4'h0;
      end else if (taken) begin
         nb <= 4'h0;
      end else if (rd_ack) begin
         nb <= nb + 4'h1;
      end
   end
   function automatic int unsigned exec_cyc(input logic [15:0] c);
      return (c == `SMC_CMD_SERIAL) ? SERIAL_CYC :
         (c == `SMC_CMD_SELFTEST) ? SELFTEST_CYC : VARIANT_CYC;
   endfunction : exec_cyc
   // ==========================================================
   // properties
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);
   sequence s_take;
      taken && (cmd_code inside {`SMC_CMD_SERIAL, `SMC_CMD_SELFTEST,
         `SMC_CMD_FACTORY, `SMC_CMD_REINIT, `SMC_CMD_VARIANT});
   endsequence
   sequence s_busy;
      !cmd_ready [*2];
   endsequence
   sequence s_answer;
      rd_ack || rd_nack;
   endsequence
   property p_busy_after_take;
      s_take |=> s_busy;
   endproperty
   a_busy_after_take: assert property (p_busy_after_take)
      else $error("link ready stayed high after a command");
   property p_req_answered;
      rd_req |=> s_answer;
   endproperty
   a_req_answered: assert property (p_req_answered)
      else $error("read request got no answer next cycle");
   property p_exclusive;
      !(rd_ack && rd_nack);
   endproperty
   a_exclusive: assert property (p_exclusive)
      else $error("ack and nack together");
   property p_wait_exec;
      rd_ack |-> since > exec_cyc(last_code);
   endproperty
   a_wait_exec: assert property (p_wait_exec)
      else $error("read acknowledged before execution ended");
   property p_no_data;
      rd_ack |-> !(last_code inside {`SMC_CMD_FACTORY, `SMC_CMD_REINIT});
   endproperty
   a_no_data: assert property (p_no_data)
      else $error("data sent for a command without answer");
   property p_last_pos;
      rd_ack |-> (rd_last == (nb == ((last_code == `SMC_CMD_SERIAL) ? 8 : 2)));
   endproperty
   a_last_pos: assert property (p_last_pos)
      else $error("last byte flag at wrong position");
   property p_serial_msb;
      rd_ack && nb == 4'h0 && last_code == `SMC_CMD_SERIAL
         |-> rd_data == SERIAL[47:40];
   endproperty
   a_serial_msb: assert property (p_serial_msb)
      else $error("serial does not start with its top byte");
   property p_variant_top;
      rd_ack && nb == 4'h0 && last_code == `SMC_CMD_VARIANT
         |-> rd_data[7:4] == VARIANT;
   endproperty
   a_variant_top: assert property (p_variant_top)
      else $error("variant not in top four bits");
endmodule : smc_link_checker
`default_nettype wire

// [verification/tb_sensor_maintenance_commands.sv]
// Purpose: end to end bench, host and sensor ends joined by the link
// Assumes: execution counts shortened, same self-test, serial and variant values for both ends
// Notes: answer bytes rebuilt by a queue model and compared
`timescale 1ns/100ps
`default_nettype none
`include "smc_regs.svh"
module tb_sensor_maintenance_commands;
   localparam logic [47:0] SER = 48'h5a3c_0f96_e1d2; // arbitrary value
   localparam logic [3:0] VAR = 4'h9; // arbitrary value
   localparam logic [11:0] VLO = 12'h2c4;
   // shortened execution counts, host waits match the sensor end for self-test, serial and variant
   localparam int unsigned T_ST = 40;
   localparam int unsigned T_FR = 30;
   localparam int unsigned T_RI = 20;
   localparam int unsigned T_SH = 10;
   localparam logic [15:0] CMDS [5] = '{`SMC_CMD_SERIAL, `SMC_CMD_SELFTEST,
      `SMC_CMD_FACTORY, `SMC_CMD_REINIT, `SMC_CMD_VARIANT};
   logic clk_i, nrst_i, req_i, meas_i, fault_i;
   logic [15:0] req_cmd_i, code_i, selftest;
   logic busy, done, crc_err, fact, clr_f, clr_a, reload, dbusy;
   logic [47:0] serial;
   logic [3:0] variant;
   logic [31:0] rnd = 32'h35b7c3f1;
   logic [7:0] rx[$], ex[$];
   int n_fact, n_clr, n_rel, n_take, r0, t0, n_mismatch, total_checks;
   int n_nak;
   // ==========================================================
   // the two ends and the checker
   smc_if link();
   smc_dev #(.SERIAL(SER), .VARIANT(VAR), .VAR_LOW(VLO), .SELFTEST_CYC(T_ST),
      .FACTORY_CYC(T_FR), .REINIT_CYC(T_RI), .VARIANT_CYC(T_SH),
      .SERIAL_CYC(T_SH))
      smc_dev_inst (.clk_i(clk_i), .nrst_i(nrst_i), .link(link),
      .selftest_fault_i(fault_i), .selftest_code_i(code_i),
      .factory_restore_o(fact), .clear_forced_recalibration_o(clr_f),
      .clear_automatic_baseline_correction_o(clr_a),
      .reload_settings_o(reload), .busy_o(dbusy));
   smc_host #(.SELFTEST_CYC(T_ST), .SHORT_CYC(T_SH)) smc_host_inst (
      .clk_i(clk_i), .nrst_i(nrst_i), .link(link), .req_i(req_i),
      .req_cmd_i(req_cmd_i), .meas_running_i(meas_i), .busy_o(busy),
      .done_o(done), .crc_err_o(crc_err), .serial_o(serial),
      .variant_o(variant), .selftest_o(selftest));
   smc_link_checker #(.SELFTEST_CYC(T_ST), .VARIANT_CYC(T_SH),
      .SERIAL_CYC(T_SH),
      .SERIAL(SER), .VARIANT(VAR)) smc_link_checker_inst (.clk_i(clk_i),
      .nrst_i(nrst_i), .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code),
      .cmd_ready(link.cmd_ready), .rd_req(link.rd_req), .rd_ack(link.rd_ack),
      .rd_nack(link.rd_nack), .rd_data(link.rd_data), .rd_last(link.rd_last));
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // bytes and side pulses counted as the wires show them
   always @(posedge clk_i) begin
      if (link.rd_ack === 1'b1) begin
         rx.push_back(link.rd_data);
      end
      n_fact += (fact === 1'b1);
      n_clr += (clr_f === 1'b1) + (clr_a === 1'b1);
      n_rel += (reload === 1'b1);
      n_nak += (link.rd_nack === 1'b1);
      n_take += (link.cmd_valid === 1'b1 && link.cmd_ready === 1'b1);
   end
   // ==========================================================
   // model and helpers
   function automatic logic [7:0] crc8(input logic [15:0] w);
      logic [7:0] c;
      c = 8'hff;
      for (int i = 15; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
      end
      return c;
   endfunction : crc8
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic push_word(input logic [15:0] w);
      ex.push_back(w[15:8]);
      ex.push_back(w[7:0]);
      ex.push_back(crc8(w));
   endtask : push_word
   task automatic check(input string what, input logic [47:0] seen,
      input logic [47:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done
   // bounded waits, a spent bound ends the run
   task automatic timeout();
      n_mismatch++;
      $display("CHECK FAILED completion expected 1 seen timeout");
      test_done();
   endtask : timeout
   task automatic run_cmd(input logic [15:0] cmd, input logic flt,
      input logic [15:0] code);
      logic [15:0] st;
      int f0, c0, r1;
      @(negedge clk_i);
      fault_i = flt;
      code_i = code;
      st = !flt ? 16'h0000 : (code == 16'h0000) ? 16'h0001 : code;
      ex.delete();
      rx.delete();
      if (cmd == `SMC_CMD_SERIAL) begin
         for (int i = 2; i >= 0; i--) begin
            push_word(SER[16 * i +: 16]);
         end
      end
      if (cmd == `SMC_CMD_SELFTEST) begin
         push_word(st);
      end
      if (cmd == `SMC_CMD_VARIANT) begin
         push_word({VAR, VLO});
      end
      f0 = n_fact;
      c0 = n_clr;
      r1 = n_rel;
      req_cmd_i = cmd;
      req_i = 1'b1;
      @(negedge clk_i);
      req_i = 1'b0;
      for (int k = 0; done !== 1'b1; k++) begin
         if (k == 4000) timeout();
         @(posedge clk_i);
         #1;
      end
      for (int k = 0; dbusy !== 1'b0; k++) begin
         if (k == 4000) timeout();
         @(posedge clk_i);
         #1;
      end
      // end pulses are registered, let one more edge land
      @(posedge clk_i);
      #1;
      check("byte count", 48'(rx.size()), 48'(ex.size()));
      foreach (ex[i]) begin
         check("answer byte", 48'(rx[i]), 48'(ex[i]));
      end
      check("restore", 48'(n_fact - f0), 48'(cmd == `SMC_CMD_FACTORY));
      check("clears", 48'(n_clr - c0), 48'(2 * (cmd == `SMC_CMD_FACTORY)));
      check("reload", 48'(n_rel - r1), 48'(cmd == `SMC_CMD_REINIT));
      check("crc error", 48'(crc_err), 48'h0);
      // a host that waits the full time never meets a refused read
      check("refused reads", 48'(n_nak), 48'h0);
      check("host busy", 48'(busy), 48'h0);
      if (cmd == `SMC_CMD_SERIAL) check("serial", serial, SER);
      if (cmd == `SMC_CMD_VARIANT) check("variant", 48'(variant), 48'(VAR));
      if (cmd == `SMC_CMD_SELFTEST) check("self test", 48'(selftest), 48'(st));
   endtask : run_cmd
   // ==========================================================
   // main sequence
   initial begin
      nrst_i = 1'b0;
      req_i = 1'b0;
      meas_i = 1'b0;
      fault_i = 1'b0;
      req_cmd_i = 16'h0000;
      code_i = 16'h0000;
      repeat (16) @(posedge clk_i);
      @(negedge clk_i);
      nrst_i = 1'b1;
      foreach (CMDS[i]) begin
         run_cmd(CMDS[i], 1'b0, 16'h0000);
      end
      run_cmd(`SMC_CMD_SELFTEST, 1'b1, 16'h0000);
      // reinit is held off while a measurement runs
      @(negedge clk_i);
      meas_i = 1'b1;
      r0 = n_rel;
      t0 = n_take;
      req_cmd_i = `SMC_CMD_REINIT;
      req_i = 1'b1;
      @(negedge clk_i);
      req_i = 1'b0;
      repeat (60) @(negedge clk_i);
      check("held reload", 48'(n_rel - r0), 48'h0);
      check("held command", 48'(n_take - t0), 48'h0);
      meas_i = 1'b0;
      repeat (60) @(negedge clk_i);
      // random order and random fault codes, back to back
      repeat (12) begin
         rnd = lfsr(rnd);
         run_cmd(CMDS[rnd[2:0] % 5], rnd[8], rnd[31:16]);
      end
      test_done();
   end
endmodule : tb_sensor_maintenance_commands
`default_nettype wire
